// file: include/nrds_map.vh
// Constants for the non-restoring divide sequencer
// Overview of operation
// - Align divisor by 35 places, then run up to 36 iterations.
// - Each iteration shifts, sets quotient bit, adds/subtracts divisor, shifts quotient.
// - Subtract when remainder and divisor signs match, else add; weights descend.
// - Subtracting inserts one in quotient lsb stage; adding inserts zero.
// - Negative final remainder gets plus divisor magnitude; quotient adjusted by one.
// - Quotient beyond plus or minus (2^35 - 1) flags accumulator fault and halts, so -2^35 also faults.
// - Divide check runs every iteration and stops the sequence early.
// - Negative dividend uses the same alternating procedure.
// - Negative dividend gets initial divisor correction and an end correction.
// - 72-bit dividend in accumulator, divisor register, quotient register, remainder left.
// - Extended divisor is 72 bits: low half divisor, high half its sign.
// - Dividend equals divisor times quotient plus non-negative remainder.
`ifndef NRDS_MAP_VH
`define NRDS_MAP_VH
`define NRDS_WORD_W      36
`define NRDS_ACC_W       72
`define NRDS_ALIGN_SHIFT 36
`define NRDS_ITER_COUNT  36
`define NRDS_QW_W        40
`define NRDS_CNT_W       6
`define NRDS_CNT_TOP     6'h23
`define NRDS_Q_MAX       40'h07FFFFFFFF
`define NRDS_Q_MIN       40'hF800000001
`endif

// file: src/nrds_addsub.v
// 72-bit add/subtract unit for the divide accumulator
module nrds_addsub (
	// Operands
	input  wire [71:0] accIn,
	input  wire [71:0] operandIn,
	input  wire        subtract,
	// Result
	output wire [71:0] sumOut
);
	assign sumOut = subtract ? (accIn - operandIn) : (accIn + operandIn);
endmodule

// file: src/nrds_divider.v
// Non-restoring divide sequencer and datapath
`include "nrds_map.vh"
module nrds_divider (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        clkEn,
	// Command from instruction control
	input  wire        start,
	input  wire [71:0] dividendIn,
	input  wire [35:0] divisorIn,
	// Results
	output reg  [35:0] quotientOut,
	output reg  [71:0] remainderOut,
	output reg         done,
	output wire        busy,
	// Fault and halt
	output reg         accFault,
	output wire        haltReq
);
	////////////////////////////////////////////////////////////////////
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_ALIGN = 5'h02;
	localparam [4:0] ST_ITER  = 5'h04;
	localparam [4:0] ST_FIX   = 5'h08;
	localparam [4:0] ST_HALT  = 5'h10;

	reg  [4:0]                   state_reg;
	reg  [4:0]                   state_next;
	reg  [71:0]                  acc_reg;
	reg  [71:0]                  alignDiv_reg;
	reg  [35:0]                  div_reg;
	reg  [35:0]                  quot_reg;
	reg  [`NRDS_QW_W-1:0]        qWeight_reg;
	reg  [`NRDS_CNT_W-1:0]       cnt_reg;
	reg                          negDividend_reg;
	reg  [71:0]                  addOperand;
	reg                          addSub;
	wire [71:0]                  accSum;
	wire                         sameSign;
	wire                         quotientLsbStage;
	wire [`NRDS_QW_W-1:0]        qWeight_next;
	wire [`NRDS_QW_W-1:0]        stepWeight;
	wire                         qOverflow;
	reg  [35:0]                  quotFinal;
	reg  [`NRDS_QW_W-1:0]        qFinalWide;
	wire                         finalOver;

	////////////////////////////////////////////////////////////////////
	// Sign extension of a single-length word to double length
	function [71:0] dext;
		input [35:0] w;
		begin
			dext = {{36{w[35]}}, w};
		end
	endfunction

	// Weight 2^k on the quotient scale
	function [`NRDS_QW_W-1:0] pow2;
		input [`NRDS_CNT_W-1:0] k;
		begin
			pow2 = {{(`NRDS_QW_W-1){1'b0}}, 1'b1} << k;
		end
	endfunction

	// Signed greater-than on the quotient scale
	function sgt;
		input [`NRDS_QW_W-1:0] a;
		input [`NRDS_QW_W-1:0] b;
		begin
			sgt = $signed(a) > $signed(b);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	assign busy    = (state_reg == ST_ALIGN) || (state_reg == ST_ITER) ||
	                 (state_reg == ST_FIX);
	assign haltReq = accFault;

	// sign comparison
	// A zero partial remainder counts as positive.
	assign sameSign = (acc_reg[71] == div_reg[35]);
	assign quotientLsbStage = sameSign;
	assign stepWeight       = pow2(cnt_reg);
	assign qWeight_next     = sameSign ? (qWeight_reg + stepWeight)
	                                   : (qWeight_reg - stepWeight);

	// early divide check
	// Remaining weights can still move the quotient by at most 2^k - 1.
	assign qOverflow = sgt(qWeight_next - (stepWeight - 40'h0000000001), `NRDS_Q_MAX) ||
	                   sgt(`NRDS_Q_MIN, qWeight_next + (stepWeight - 40'h0000000001));

	// Operand selection for the shared adder
	always @* begin
		addOperand = dext(div_reg);
		addSub     = 1'b0;
		case (state_reg)
			ST_ALIGN: begin
				// Latched divisor, so the command operands need not be held
				addOperand = dext(div_reg);
				addSub     = 1'b0;
			end
			ST_ITER: begin
				addOperand = alignDiv_reg;
				addSub     = sameSign;
			end
			ST_FIX: begin
				// Adds the divisor magnitude
				addOperand = dext(div_reg);
				addSub     = div_reg[35];
			end
			default: begin
				addOperand = dext(div_reg);
				addSub     = 1'b0;
			end
		endcase
	end

	nrds_addsub u_addsub (
		.accIn     (acc_reg),
		.operandIn (addOperand),
		.subtract  (addSub),
		.sumOut    (accSum)
	);

	// Final quotient from the inserted bits, then end corrections
	always @* begin
		quotFinal  = {quot_reg[34:0], 1'b1};
		qFinalWide = qWeight_reg;
		if (negDividend_reg) begin
			quotFinal  = quotFinal - 36'h000000001;
			qFinalWide = qFinalWide - 40'h0000000001;
		end
		if (acc_reg[71]) begin
			if (div_reg[35]) begin
				quotFinal  = quotFinal + 36'h000000001;
				qFinalWide = qFinalWide + 40'h0000000001;
			end else begin
				quotFinal  = quotFinal - 36'h000000001;
				qFinalWide = qFinalWide - 40'h0000000001;
			end
		end
	end

	// end correction check
	// The one-unit end adjustments could wrap a boundary quotient silently.
	assign finalOver = sgt(qFinalWide, `NRDS_Q_MAX) || sgt(`NRDS_Q_MIN, qFinalWide);

	////////////////////////////////////////////////////////////////////
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				state_next = ST_ITER;
			end
			ST_ITER: begin
				if (qOverflow) begin
					state_next = ST_HALT;
				end else if (cnt_reg == {`NRDS_CNT_W{1'b0}}) begin
					state_next = ST_FIX;
				end
			end
			ST_FIX: begin
				if (finalOver) begin
					state_next = ST_HALT;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_HALT: begin
				// Machine stays stopped until reset
				state_next = ST_HALT;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg       <= ST_IDLE;
			acc_reg         <= 72'h000000000000000000;
			alignDiv_reg    <= 72'h000000000000000000;
			div_reg         <= 36'h000000000;
			quot_reg        <= 36'h000000000;
			qWeight_reg     <= 40'h0000000000;
			cnt_reg         <= 6'h00;
			negDividend_reg <= 1'b0;
			quotientOut     <= 36'h000000000;
			remainderOut    <= 72'h000000000000000000;
			done            <= 1'b0;
			accFault        <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
			done      <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						acc_reg         <= dividendIn;
						div_reg         <= divisorIn;
						negDividend_reg <= dividendIn[71];
						quot_reg        <= 36'h000000000;
						qWeight_reg     <= 40'h0000000000;
					end
				end
				ST_ALIGN: begin
					// 35-place alignment
					// Shifting the divisor up instead of the accumulator keeps A in place.
					alignDiv_reg <= dext(div_reg) << `NRDS_ALIGN_SHIFT - 1;
					cnt_reg      <= `NRDS_CNT_TOP;
					if (negDividend_reg) begin
						acc_reg <= accSum;
					end
				end
				ST_ITER: begin
					acc_reg      <= accSum;
					alignDiv_reg <= {alignDiv_reg[71], alignDiv_reg[71:1]};
					quot_reg     <= {quot_reg[34:0], quotientLsbStage};
					qWeight_reg  <= qWeight_next;
					cnt_reg      <= cnt_reg - 6'h01;
					if (qOverflow) begin
						accFault <= 1'b1;
					end
				end
				ST_FIX: begin
					if (finalOver) begin
						accFault <= 1'b1;
					end else begin
						if (acc_reg[71]) begin
							remainderOut <= accSum;
							acc_reg      <= accSum;
						end else begin
							remainderOut <= acc_reg;
						end
						quotientOut <= quotFinal;
						quot_reg    <= quotFinal;
						done        <= 1'b1;
					end
				end
				ST_HALT: begin
					accFault <= 1'b1;
				end
				default: begin
					accFault <= accFault;
				end
			endcase
		end
	end
endmodule

// file: test/nrds_props.sv
// Port assertions for the divide sequencer
module nrds_props (
	// Clock and reset
	input logic        sys_clk,
	input logic        rst_b,
	input logic        clkEn,
	// Command
	input logic        start,
	input logic [71:0] dividendIn,
	input logic [35:0] divisorIn,
	// Results
	input logic [35:0] quotientOut,
	input logic [71:0] remainderOut,
	input logic        done,
	input logic        busy,
	input logic        accFault,
	input logic        haltReq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	wire take = start && clkEn && !busy && !accFault;
	wire posPos = !dividendIn[71] && !divisorIn[35];
	////////////////////////////////////////////////////////////////
	busy_runs_a: assert property (
		take |=> (busy || accFault)[*8]) else $error("busy missing after start");
	done_time_a: assert property (
		take |-> ##39 (done || accFault)) else $error("done not at cycle 39");
	fault_sticky_a: assert property (
		accFault |=> accFault && haltReq) else $error("fault or halt dropped");
	fault_rise_a: assert property (
		$rose(accFault) |-> $past(busy) && haltReq) else $error("fault outside sequence");
	no_result_a: assert property (
		accFault |-> !done) else $error("results after fault");
	rem_sign_a: assert property (
		done |-> !remainderOut[71] && !busy) else $error("remainder negative");
	hold_res_a: assert property (
		!done |-> $stable(quotientOut) && $stable(remainderOut)) else $error("results moved");
	pos_quot_a: assert property (
		take && posPos |-> ##39 (accFault || !quotientOut[35])) else $error("quotient sign");
	cover property (take);
	cover property ($rose(accFault));
	cover property (done && quotientOut[35]);
	cover property (take && dividendIn[71]);
endmodule
bind nrds_divider nrds_props u_props (.sys_clk, .rst_b, .clkEn, .start, .dividendIn,
	.divisorIn, .quotientOut, .remainderOut, .done, .busy, .accFault, .haltReq);

// file: test/nrds_ctrl_model.sv
// Instruction control stand-in that issues divide commands
module nrds_ctrl_model (
	// Clock
	input  logic        sys_clk,
	// Command to divider
	output logic        start,
	output logic [71:0] dividendIn,
	output logic [35:0] divisorIn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		start = 1'b0;
		dividendIn = 72'h0;
		divisorIn = 36'h0;
	end
	// Operands held two cycles, then inverted so stale reads show up
	task automatic issue(input logic [71:0] dd, input logic [35:0] dv);
		@(negedge sys_clk);
		start = 1'b1;
		dividendIn = dd;
		divisorIn = dv;
		@(negedge sys_clk);
		start = 1'b0;
		@(negedge sys_clk);
		dividendIn = ~dd;
		divisorIn = ~dv;
	endtask
endmodule

// file: test/nrds_divider_tb.sv
// Self-checking bench for the divide sequencer
module nrds_divider_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        clkEn = 1'b1;
	wire         start;
	wire  [71:0] dividendIn;
	wire  [35:0] divisorIn;
	wire  [35:0] quotientOut;
	wire  [71:0] remainderOut;
	wire         done, busy, accFault, haltReq;
	int          n_fail = 0;
	int          num_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	nrds_ctrl_model CTRL (.sys_clk, .start, .dividendIn, .divisorIn);
	nrds_divider DUT (.sys_clk, .rst_b, .clkEn, .start, .dividendIn, .divisorIn,
		.quotientOut, .remainderOut, .done, .busy, .accFault, .haltReq);
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic run(input logic [71:0] dd, input logic [35:0] dv, input logic expFault,
		input int lim = 37);
		logic signed [71:0] sum;
		logic [71:0] mag;
		int i;
		CTRL.issue(dd, dv);
		i = 0;
		while (done !== 1'b1 && accFault !== 1'b1 && i < 60) begin
			@(negedge sys_clk);
			i++;
		end
		sum = $signed(dv) * $signed(quotientOut) + $signed(remainderOut);
		mag = dv[35] ? -{{36{dv[35]}}, dv} : {{36{dv[35]}}, dv};
		if (expFault) begin
			check(accFault === 1'b1 && haltReq === 1'b1 && i < lim, "no divide check");
			check(done === 1'b0, "result after fault");
			@(negedge sys_clk);
			rst_b = 1'b0;
			repeat (6) @(negedge sys_clk);
			rst_b = 1'b1;
		end else begin
			check(done === 1'b1 && accFault === 1'b0, "no done");
			check(sum === dd, "divisor times quotient plus remainder");
			check(remainderOut[71] === 1'b0 && remainderOut <= mag, "remainder range");
		end
	endtask
	task automatic t_pos(); run(72'd14, 36'd4, 1'b0); endtask
	task automatic t_ndiv(); run(72'd14, -36'd3, 1'b0); endtask
	task automatic t_ndend(); run(-72'd22, -36'd3, 1'b0); endtask
	task automatic t_qmax(); run(72'd34359738367 * 72'd7 + 72'd6, 36'd7, 1'b0); endtask
	task automatic t_qmin(); run(-72'd34359738367 * 72'd5 + 72'd2, 36'd5, 1'b0); endtask
	task automatic t_over(); run(72'd34359738368 * 72'd3, 36'd3, 1'b1); endtask
	task automatic t_nover(); run(-72'd34359738368 * 72'd5, 36'd5, 1'b1, 38); endtask
	task automatic t_nwrap(); run(-72'd34359738368 * 72'd5 - 72'd5, 36'd5, 1'b1, 38); endtask
	task automatic t_nlow(); run(-72'd34359738368 * 72'd5 - 72'd10, 36'd5, 1'b1); endtask
	task automatic t_zero(); run(72'd9, 36'h0, 1'b1); endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		t_pos();
		t_ndiv();
		t_ndend();
		t_qmax();
		t_qmin();
		t_over();
		t_nover();
		t_nwrap();
		t_nlow();
		t_zero();
		t_pos();
		wrap_up();
	end
	initial begin
		repeat (2000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end
endmodule
